// File: tmrc_pkg.sv
// Package for the sixteen-bit timer/counter: register map, field layout, reset values.
// Assumes an APB slave with 32-bit data; every register takes one aligned word.
package tmrc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_COUNT_LOW = 8'h04;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h08;
    localparam logic [7:0] OFF_OSC_CONTROL = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;

    // Control field positions
    localparam int BIT_WIDE = 7;
    localparam int BIT_SYSCLK_TICK = 6;
    localparam int BIT_PRESCALE_HI = 5;
    localparam int BIT_PRESCALE_LO = 4;
    localparam int BIT_OSC_EN = 3;
    localparam int BIT_SYNC_DIS = 2;
    localparam int BIT_SRC_SEL = 1;
    localparam int BIT_RUN = 0;

    // Oscillator control field positions
    localparam int BIT_IDLE_ON_SLEEP = 7;
    localparam int BIT_SCS_HI = 1;
    localparam int BIT_SCS_LO = 0;
    localparam logic [1:0] SCS_TICK_OSC = 2'h1;

    // Status field positions
    localparam int BIT_OVF = 0;
    localparam int BIT_OVF_IE = 1;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] OSC_RESET = 8'h00;

    // Special event trigger compare mode code
    localparam logic [3:0] CMP_MODE_SPECIAL = 4'hb;

    // Instruction cycle is four oscillator periods
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

    // Power modes of the device clock
    typedef enum logic [1:0] {
        PWR_PRI_RUN,
        PWR_SEC_RUN,
        PWR_SEC_IDLE,
        PWR_SLEEP
    } tmrc_pwr_e;

    // Control register fields
    typedef struct packed {
        logic wide_access_enable;
        logic sysclk_from_tick_osc;
        logic [1:0] input_prescale_select;
        logic tick_osc_enable;
        logic ext_sync_disable;
        logic count_source_select;
        logic timer_run;
    } tmrc_ctrl_s;

endpackage : tmrc_pkg

// File: tmrc_timer.sv
// Sixteen-bit up-counting timer/counter with an APB register slave.
// Assumes ext_count_pin_in and crystal_in_pin_in are sampled as levels on mclk_in.
// Assumes both count sources are slow next to mclk_in, one edge per few cycles.
// Assumes trigger, sleep and wake requests arrive as one-cycle pulses.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module tmrc_timer (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Count sources and pins
    input wire logic ext_count_pin_in,
    input wire logic crystal_in_pin_in,
    input wire logic [1:0] port_direction_in,
    input wire logic [1:0] port_pin_level_in,
    output logic [1:0] pin_oe_n_out,
    output logic tick_osc_power_out,
    // System events
    input wire logic [3:0] cmp_mode_in,
    input wire logic special_trigger_in,
    input wire logic sleep_cmd_in,
    input wire logic wake_in,
    output logic [1:0] power_mode_out,
    output logic overflow_irq_out
);

    // Register file and counting state
    tmrc_pkg::tmrc_ctrl_s ctrl_q;
    logic [7:0] osc_ctrl_q;
    tmrc_pkg::tmrc_pwr_e pwr_q;
    logic [15:0] count_q;
    logic [7:0] hbuf_q;
    logic [2:0] pre_q;
    logic [1:0] instr_q;
    logic ext_s1_q, ext_s2_q, ext_prev_q;
    logic raw_prev_q;
    // Flags sit apart from the control word so software clears them alone
    logic ovf_q, ovf_ie_q;
    logic [31:0] rdata_d;

    // Simple decode helper shared by reads and writes.
    // Exact match, so a misaligned address falls through to the error path.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Prescale terminal count; a power of two minus one.
    // Gives 0, 1, 3 or 7, held against the running prescale count.
    function automatic logic [2:0] pre_last(input logic [1:0] sel);
        pre_last = 3'((4'h1 << sel) - 4'h1);
    endfunction : pre_last

    // Access-cycle strobes; ready is always high there, so it needs no gating
    logic wr_acc, rd_acc;
    assign wr_acc = psel_in & penable_in & pwrite_in;
    assign rd_acc = psel_in & penable_in & ~pwrite_in;

    // One write strobe per register, plus a low-byte read strobe; an unmapped address raises none of them
    logic wr_ctrl, wr_low, wr_high, wr_osc, wr_stat, rd_low;
    assign wr_ctrl = wr_acc & hit(paddr_in, tmrc_pkg::OFF_CONTROL);
    assign wr_low = wr_acc & hit(paddr_in, tmrc_pkg::OFF_COUNT_LOW);
    assign wr_high = wr_acc & hit(paddr_in, tmrc_pkg::OFF_COUNT_HIGH);
    assign wr_osc = wr_acc & hit(paddr_in, tmrc_pkg::OFF_OSC_CONTROL);
    assign wr_stat = wr_acc & hit(paddr_in, tmrc_pkg::OFF_STATUS);
    assign rd_low = rd_acc & hit(paddr_in, tmrc_pkg::OFF_COUNT_LOW);

    // External source: crystal when its oscillator is on, else the pin.
    // Turning the oscillator on swaps sources under the edge detector, so
    // software should enable it before it sets the run bit.
    logic raw_src;
    assign raw_src = ctrl_q.tick_osc_enable ? crystal_in_pin_in : ext_count_pin_in;

    // Two-flop synchroniser; only the second stage feeds edge detection.
    // Two cycles of delay keep metastable levels away from the count.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_prev_q <= 1'b0;
            raw_prev_q <= 1'b0;
        end else begin
            ext_s1_q <= raw_src;
            ext_s2_q <= ext_s1_q;
            ext_prev_q <= ext_s2_q;
            raw_prev_q <= raw_src;
        end
    end

    // Unsynchronised path skips two stages of latency, not the sampling clock.
    // With the internal source selected neither path is looked at.
    logic ext_edge;
    assign ext_edge = ctrl_q.ext_sync_disable ? (raw_src & ~raw_prev_q)
                                              : (ext_s2_q & ~ext_prev_q);

    // Instruction cycle divider, free running.
    // Not restarted by the run bit, so the first tick may come early.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            instr_q <= 2'h0;
        end else begin
            instr_q <= 2'(instr_q + 2'h1);
        end
    end

    // Count input: instruction cycle or a qualified external edge
    logic tick_in;
    assign tick_in = ctrl_q.count_source_select ? ext_edge
                                                : (instr_q == tmrc_pkg::INSTR_DIV_LAST);

    // Prescaler and its output pulse
    logic pre_out;
    assign pre_out = ctrl_q.timer_run & tick_in
                     & (pre_q >= pre_last(ctrl_q.input_prescale_select));

    // Prescale count; only a low-byte write restarts it
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pre_q <= 3'h0;
        end else if (wr_low) begin
            pre_q <= 3'h0;
        end else if (ctrl_q.timer_run & tick_in) begin
            pre_q <= pre_out ? 3'h0 : 3'(pre_q + 3'h1);
        end
    end

    // Counter; software write beats the special event, which beats counting.
    // A byte-mode high write swallows a tick that lands in the same cycle.
    // Only compare mode 1011 may reset; other modes leave the count alone.
    logic special;
    assign special = special_trigger_in & (cmp_mode_in == tmrc_pkg::CMP_MODE_SPECIAL);

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            count_q <= 16'h0000;
        end else if (wr_low) begin
            count_q[7:0] <= pwdata_in[7:0];
            if (ctrl_q.wide_access_enable) begin
                count_q[15:8] <= hbuf_q;
            end
        end else if (wr_high & ~ctrl_q.wide_access_enable) begin
            count_q[15:8] <= pwdata_in[7:0];
        end else if (special) begin
            count_q <= 16'h0000;
        end else if (pre_out) begin
            count_q <= 16'(count_q + 16'h0001);
        end
    end

    // High byte buffer, used only in 16-bit mode.
    // A high write and a low read never share a cycle, so their order is free.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            hbuf_q <= 8'h00;
        end else if (ctrl_q.wide_access_enable & wr_high) begin
            hbuf_q <= pwdata_in[7:0];
        end else if (ctrl_q.wide_access_enable & rd_low) begin
            hbuf_q <= count_q[15:8];
        end
    end

    // Overflow flag: a wrap in the clearing cycle still sets it.
    // In 16-bit mode a high write only fills the buffer, so the count still wraps.
    logic wrap;
    assign wrap = pre_out & (count_q == 16'hffff) & ~wr_low & ~special
                  & ~(wr_high & ~ctrl_q.wide_access_enable);

    // Status: writing one clears the flag; the enable is written directly
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ovf_q <= 1'b0;
            ovf_ie_q <= 1'b0;
        end else begin
            if (wrap) begin
                ovf_q <= 1'b1;
            end else if (wr_stat & pwdata_in[tmrc_pkg::BIT_OVF]) begin
                ovf_q <= 1'b0;
            end
            if (wr_stat) begin
                ovf_ie_q <= pwdata_in[tmrc_pkg::BIT_OVF_IE];
            end
        end
    end

    // Control register; bit 6 is not writable.
    // Bit 6 trails the power mode by one cycle, too short for software to see.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ctrl_q <= tmrc_pkg::tmrc_ctrl_s'(tmrc_pkg::CONTROL_RESET);
        end else begin
            if (wr_ctrl) begin
                ctrl_q.wide_access_enable <= pwdata_in[tmrc_pkg::BIT_WIDE];
                ctrl_q.input_prescale_select <=
                    pwdata_in[tmrc_pkg::BIT_PRESCALE_HI:tmrc_pkg::BIT_PRESCALE_LO];
                ctrl_q.tick_osc_enable <= pwdata_in[tmrc_pkg::BIT_OSC_EN];
                ctrl_q.ext_sync_disable <= pwdata_in[tmrc_pkg::BIT_SYNC_DIS];
                ctrl_q.count_source_select <= pwdata_in[tmrc_pkg::BIT_SRC_SEL];
                ctrl_q.timer_run <= pwdata_in[tmrc_pkg::BIT_RUN];
            end
            ctrl_q.sysclk_from_tick_osc <= (pwr_q == tmrc_pkg::PWR_SEC_RUN) ||
                                           (pwr_q == tmrc_pkg::PWR_SEC_IDLE);
        end
    end

    // Oscillator control register
    // Clock select and idle-on-sleep are plain storage read by the mode machine
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            osc_ctrl_q <= tmrc_pkg::OSC_RESET;
        end else if (wr_osc) begin
            osc_ctrl_q <= pwdata_in[7:0];
        end
    end

    // Power mode; start-up delay before selecting the crystal is software's job.
    // Sleep with another clock selected is full sleep; wake returns to primary.
    logic scs_tick;
    assign scs_tick =
        osc_ctrl_q[tmrc_pkg::BIT_SCS_HI:tmrc_pkg::BIT_SCS_LO] == tmrc_pkg::SCS_TICK_OSC;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pwr_q <= tmrc_pkg::PWR_PRI_RUN;
        end else begin
            case (pwr_q)
                tmrc_pkg::PWR_PRI_RUN, tmrc_pkg::PWR_SEC_RUN: begin
                    if (sleep_cmd_in & scs_tick & ~osc_ctrl_q[tmrc_pkg::BIT_IDLE_ON_SLEEP]) begin
                        pwr_q <= tmrc_pkg::PWR_SEC_IDLE;
                    end else if (sleep_cmd_in & ~scs_tick) begin
                        pwr_q <= tmrc_pkg::PWR_SLEEP;
                    end else if (scs_tick) begin
                        pwr_q <= tmrc_pkg::PWR_SEC_RUN;
                    end else begin
                        pwr_q <= tmrc_pkg::PWR_PRI_RUN;
                    end
                end
                tmrc_pkg::PWR_SEC_IDLE: begin
                    if (wake_in) begin
                        pwr_q <= tmrc_pkg::PWR_SEC_RUN;
                    end
                end
                default: begin
                    if (wake_in) begin
                        pwr_q <= tmrc_pkg::PWR_PRI_RUN;
                    end
                end
            endcase
        end
    end

    // Read mux; the live high byte never reaches the bus in 16-bit mode.
    // Decoded from the setup address; the answer flop carries it onward.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit(paddr_in, tmrc_pkg::OFF_CONTROL)) begin
            rdata_d[7:0] = ctrl_q;
        end else if (hit(paddr_in, tmrc_pkg::OFF_COUNT_LOW)) begin
            rdata_d[7:0] = count_q[7:0];
        end else if (hit(paddr_in, tmrc_pkg::OFF_COUNT_HIGH)) begin
            rdata_d[7:0] = ctrl_q.wide_access_enable ? hbuf_q : count_q[15:8];
        end else if (hit(paddr_in, tmrc_pkg::OFF_OSC_CONTROL)) begin
            rdata_d[7:0] = osc_ctrl_q;
        end else if (hit(paddr_in, tmrc_pkg::OFF_STATUS)) begin
            rdata_d[tmrc_pkg::BIT_OVF] = ovf_q;
            rdata_d[tmrc_pkg::BIT_OVF_IE] = ovf_ie_q;
            rdata_d[3:2] = (ctrl_q.timer_run ? 2'h0 : port_pin_level_in);
        end
    end

    // Any address off the five words is refused and changes nothing
    logic unmapped;
    assign unmapped = !(hit(paddr_in, tmrc_pkg::OFF_CONTROL)
                     || hit(paddr_in, tmrc_pkg::OFF_COUNT_LOW)
                     || hit(paddr_in, tmrc_pkg::OFF_COUNT_HIGH)
                     || hit(paddr_in, tmrc_pkg::OFF_OSC_CONTROL)
                     || hit(paddr_in, tmrc_pkg::OFF_STATUS));

    // APB answer: no wait state, yet data and ready leave flops together.
    // Decoding in the setup cycle costs no extra cycle; no bus output has a combinational path.
    // The error rides with ready, so a refused access takes no longer.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in & ~penable_in;
            prdata_out <= rdata_d;
            pslverr_out <= psel_in & ~penable_in & unmapped;
        end
    end

    // Pin and oscillator outputs; oscillator power ignores power mode.
    // While stopped the pins follow the port direction bits, one meaning input.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pin_oe_n_out <= 2'h3;
            tick_osc_power_out <= 1'b0;
            power_mode_out <= 2'h0;
            overflow_irq_out <= 1'b0;
        end else begin
            pin_oe_n_out <= ctrl_q.timer_run ? 2'h3 : port_direction_in;
            tick_osc_power_out <= ctrl_q.tick_osc_enable;
            power_mode_out <= pwr_q;
            overflow_irq_out <= ovf_q & ovf_ie_q;
        end
    end

endmodule : tmrc_timer

`default_nettype wire

// File: tmrc_timer_monitor.sv
// Checker for the timer: bus answer timing, pin control, power modes, overflow mask.
// Sees only the top ports; mirrors the control bits written over the bus itself.
`timescale 1ns/1ps
`default_nettype none
module tmrc_timer_monitor (
    // Clock, reset and bus
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Pins and events
    input wire logic sleep_cmd_in,
    input wire logic [1:0] pin_oe_n_out,
    input wire logic tick_osc_power_out,
    input wire logic [1:0] power_mode_out,
    input wire logic overflow_irq_out
);
    logic run_q, osc_q, idle_q, ien_q;
    wire wr_acc = psel_in && penable_in && pready_out && pwrite_in;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // Mirror of written bits; unmapped writes are answered but never land anywhere
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            run_q <= 1'b0;
            osc_q <= 1'b0;
            idle_q <= 1'b0;
            ien_q <= 1'b0;
        end else if (wr_acc && paddr_in == tmrc_pkg::OFF_CONTROL) begin
            run_q <= pwdata_in[0];
            osc_q <= pwdata_in[3];
        end else if (wr_acc && paddr_in == tmrc_pkg::OFF_OSC_CONTROL) begin
            idle_q <= pwdata_in[7];
        end else if (wr_acc && paddr_in == tmrc_pkg::OFF_STATUS) begin
            ien_q <= pwdata_in[1];
        end
    end
    a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no answer in the cycle after setup");
    a_unmapped_error: assert property (pready_out && paddr_in > tmrc_pkg::OFF_STATUS
        |-> pslverr_out)
        else $error("unmapped access not refused");
    a_pins_input: assert property (run_q && $past(run_q) |-> pin_oe_n_out == 2'b11)
        else $error("pin driven while timer runs");
    a_port_read_zero: assert property (pready_out && !pwrite_in && paddr_in == tmrc_pkg::OFF_STATUS
        && run_q |-> prdata_out[3:2] == 2'b00)
        else $error("port bits not zero while running");
    a_osc_power: assert property (osc_q == $past(osc_q) |-> tick_osc_power_out == osc_q)
        else $error("oscillator power differs from enable");
    a_sec_run: assert property (wr_acc && paddr_in == tmrc_pkg::OFF_OSC_CONTROL
        && pwdata_in[1:0] == tmrc_pkg::SCS_TICK_OSC && power_mode_out == 2'h0
        |-> ##[1:3] power_mode_out == 2'h1)
        else $error("clock select 01 did not enter secondary run");
    a_sec_idle: assert property (power_mode_out == 2'h1 && sleep_cmd_in && !idle_q
        |-> ##[1:2] power_mode_out == 2'h2)
        else $error("sleep on secondary clock did not idle");
    a_irq_masked: assert property (!ien_q && !$past(ien_q) |-> !overflow_irq_out)
        else $error("interrupt raised while disabled");
    a_reset_state: assert property (disable iff (1'b0)
        rst_in |=> pin_oe_n_out == 2'b11 && power_mode_out == 2'h0)
        else $error("outputs not at reset values");
    c_low_write: cover property (wr_acc && paddr_in == tmrc_pkg::OFF_COUNT_LOW);
    c_overflow: cover property (overflow_irq_out);
    c_sec_idle: cover property (power_mode_out == 2'h2);
endmodule : tmrc_timer_monitor
bind tmrc_timer tmrc_timer_monitor mon_u (.mclk_in(mclk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .sleep_cmd_in(sleep_cmd_in), .pin_oe_n_out(pin_oe_n_out),
    .tick_osc_power_out(tick_osc_power_out), .power_mode_out(power_mode_out),
    .overflow_irq_out(overflow_irq_out));
`default_nettype wire

// File: tmrc_ext_src.sv
// Model of the external count pin: a burst of clean rising edges on request.
// Assumes a request comes only while no burst runs; the pin idles low.
`timescale 1ns/1ps
`default_nettype none
module tmrc_ext_src #(parameter int HALF = 4) (
    // Clock and request
    input wire logic mclk_in,
    input wire logic start_in,
    input wire logic [7:0] pulses_in,
    // Pin and status
    output logic pin_out,
    output logic busy_out
);
    // Slow edges leave room for the synchroniser to see every level
    initial begin
        pin_out = 1'b0;
        busy_out = 1'b0;
        forever begin
            @(posedge mclk_in);
            if (start_in) begin
                busy_out <= 1'b1;
                repeat (pulses_in) begin
                    repeat (HALF) @(posedge mclk_in);
                    pin_out <= 1'b1;
                    repeat (HALF) @(posedge mclk_in);
                    pin_out <= 1'b0;
                end
                busy_out <= 1'b0;
            end
        end
    end
endmodule : tmrc_ext_src
`default_nettype wire

// File: tb.sv
// Testbench for the timer: register traffic over the bus, count sources, power modes.
// Assumes the pin model tmrc_ext_src and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, npulse = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_val;
    logic pready, pslverr, ext_pin, xtal_pin, osc_pwr, irq, busy, start = 1'b0;
    logic trig = 1'b0, sleep_cmd = 1'b0, wake = 1'b0;
    logic [1:0] pdir = 2'h0, plevel = 2'h0, oe_n, pmode;
    logic [3:0] cmp_mode = 4'h0;
    logic [64:0] exp_q[$], ent;
    int num_errors = 0, cmp_count = 0, cyc = 0;
    integer seed = 32'hd7df;
    assign xtal_pin = osc_pwr & cyc[3];
    tmrc_timer dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .ext_count_pin_in(ext_pin),
        .crystal_in_pin_in(xtal_pin), .port_direction_in(pdir), .port_pin_level_in(plevel),
        .pin_oe_n_out(oe_n), .tick_osc_power_out(osc_pwr), .cmp_mode_in(cmp_mode),
        .special_trigger_in(trig), .sleep_cmd_in(sleep_cmd), .wake_in(wake),
        .power_mode_out(pmode), .overflow_irq_out(irq));
    tmrc_ext_src src_u (.mclk_in(mclk_in), .start_in(start), .pulses_in(npulse),
        .pin_out(ext_pin), .busy_out(busy));
    // 20 MHz clock
    initial forever #25 mclk_in = ~mclk_in;
    task automatic chk(input logic [32:0] seen, input logic [32:0] want);
        cmp_count++;
        if (seen !== want) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    // One bus transfer; the note of what to expect goes on the queue at setup
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] m, input logic e);
        @(posedge mclk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        exp_q.push_back({e, m, d & m});
        @(posedge mclk_in);
        penable <= 1'b1;
        do begin
            @(posedge mclk_in);
        end while (pready !== 1'b1);
        rd_val = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        apb(1'b0, a, d, m, 1'b0);
    endtask : rd
    // High first, so both byte mode and wide mode end with the full value loaded
    task automatic load(input logic [15:0] v);
        wr(tmrc_pkg::OFF_COUNT_HIGH, {24'h0, v[15:8]});
        wr(tmrc_pkg::OFF_COUNT_LOW, {24'h0, v[7:0]});
    endtask : load
    // Watcher: every completed transfer takes the oldest note off the queue
    always @(posedge mclk_in) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            ent = exp_q.pop_front();
            chk({pslverr, prdata & ent[63:32]}, {ent[64], ent[31:0]});
        end
    end
    // Hang guard, far above the thousand or so cycles the tests need
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        int w, dv, c0, c1;
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        rd(tmrc_pkg::OFF_CONTROL, 32'h0, 32'hff);
        chk(oe_n, 2'b00);
        wr(tmrc_pkg::OFF_CONTROL, 32'hff);
        rd(tmrc_pkg::OFF_CONTROL, 32'hbf, 32'hff);
        wr(tmrc_pkg::OFF_CONTROL, 32'h0);
        apb(1'b1, 8'h14, 32'hff, 32'h0, 1'b1);
        apb(1'b0, 8'h14, 32'h0, 32'hffffffff, 1'b1);
        $display("test control and refusal finished");
        wr(tmrc_pkg::OFF_CONTROL, 32'h80);
        load(16'h5aa5);
        wr(tmrc_pkg::OFF_COUNT_HIGH, 32'h33);
        rd(tmrc_pkg::OFF_COUNT_LOW, 32'ha5, 32'hff);
        rd(tmrc_pkg::OFF_COUNT_HIGH, 32'h5a, 32'hff);
        wr(tmrc_pkg::OFF_CONTROL, 32'h0);
        wr(tmrc_pkg::OFF_COUNT_HIGH, 32'h12);
        rd(tmrc_pkg::OFF_COUNT_HIGH, 32'h12, 32'hff);
        $display("test access width finished");
        for (int ps = 0; ps < 4; ps++) begin
            pdir <= 2'($random(seed));
            plevel <= 2'($random(seed));
            load(16'h0000);
            wr(tmrc_pkg::OFF_CONTROL, {26'h0, 2'(ps), 4'h1});
            c0 = cyc;
            repeat (100 + ($random(seed) & 63)) @(posedge mclk_in);
            rd(tmrc_pkg::OFF_STATUS, 32'h0, 32'hc);
            chk(oe_n, 2'b11);
            wr(tmrc_pkg::OFF_CONTROL, 32'h0);
            c1 = cyc;
            rd(tmrc_pkg::OFF_COUNT_LOW, 32'h0, 32'h0);
            w = ((c1 - c0) / 4) >> ps;
            dv = int'(rd_val[7:0]) - w;
            chk(33'(dv >= -2 && dv <= 2), 33'h1);
            repeat (20) @(posedge mclk_in);
            rd(tmrc_pkg::OFF_COUNT_LOW, rd_val, 32'hff);
        end
        $display("test prescale finished");
        for (int k = 0; k < 2; k++) begin
            load(16'h0000);
            wr(tmrc_pkg::OFF_CONTROL, (k == 1) ? 32'h07 : 32'h03);
            npulse <= (k == 1) ? 8'd5 : 8'd9;
            start <= 1'b1;
            @(posedge mclk_in);
            start <= 1'b0;
            @(posedge mclk_in);
            for (int n = 0; n < 500 && busy; n++) @(posedge mclk_in);
            wr(tmrc_pkg::OFF_CONTROL, 32'h0);
            rd(tmrc_pkg::OFF_COUNT_LOW, (k == 1) ? 32'h5 : 32'h9, 32'hff);
        end
        $display("test external source finished");
        wr(tmrc_pkg::OFF_STATUS, 32'h3);
        load(16'hfff0);
        wr(tmrc_pkg::OFF_CONTROL, 32'h1);
        for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge mclk_in);
        chk(irq, 1'b1);
        wr(tmrc_pkg::OFF_CONTROL, 32'h0);
        rd(tmrc_pkg::OFF_COUNT_HIGH, 32'h0, 32'hff);
        wr(tmrc_pkg::OFF_STATUS, 32'h3);
        repeat (2) @(posedge mclk_in);
        chk(irq, 1'b0);
        for (int k = 0; k < 2; k++) begin
            load(16'h0055);
            cmp_mode <= (k == 1) ? tmrc_pkg::CMP_MODE_SPECIAL : 4'h0;
            trig <= 1'b1;
            @(posedge mclk_in);
            trig <= 1'b0;
            rd(tmrc_pkg::OFF_COUNT_LOW, (k == 1) ? 32'h0 : 32'h55, 32'hff);
        end
        $display("test overflow and trigger finished");
        wr(tmrc_pkg::OFF_CONTROL, 32'h8);
        repeat (40) @(posedge mclk_in);
        wr(tmrc_pkg::OFF_OSC_CONTROL, 32'h1);
        repeat (3) @(posedge mclk_in);
        chk(pmode, 2'h1);
        rd(tmrc_pkg::OFF_CONTROL, 32'h48, 32'h48);
        sleep_cmd <= 1'b1;
        @(posedge mclk_in);
        sleep_cmd <= 1'b0;
        repeat (3) @(posedge mclk_in);
        chk(pmode, 2'h2);
        chk(osc_pwr, 1'b1);
        wake <= 1'b1;
        @(posedge mclk_in);
        wake <= 1'b0;
        repeat (3) @(posedge mclk_in);
        chk(pmode, 2'h1);
        wr(tmrc_pkg::OFF_OSC_CONTROL, 32'h0);
        repeat (2) @(posedge mclk_in);
        sleep_cmd <= 1'b1;
        @(posedge mclk_in);
        sleep_cmd <= 1'b0;
        repeat (3) @(posedge mclk_in);
        chk(pmode, 2'h3);
        $display("test power modes finished");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
